/* File: core/tcb_ctrl.sv */
`timescale 1ns/1ns
`include "tcb_cfg.svh"
// How it works
// - Timed run ends on timer, stop, watchdog
// - On-time code counts 20 s steps
// - Stop resets timer; enable restarts full time
// - Timed expiry sets end flag, clears enable
// - Sleep during timed run waits for end
// - Blanking darkens outputs ahead of scans
// - Watchdog stops balancing, forces sleep
// - Mode field selects timed; adjacent registers
// - Enable command byte sets enable, starts
// - Writing enable low stops balancing
// - Auto runs alone; fault halts it
// - Auto scan result checked each cycle
// - Armed auto sleeps in waits, then finally
// - Watchdog in auto: stop, flag, sleep
// - Auto cycle is on-time plus wait
// - Wait code n gives two^(n-1) seconds
// - Patterns step per cycle, wrap on zero
// - Auto cell stops when its value empties
// - Mode codes: off, manual, timed, auto
// - Subtract scans; all zero ends auto
// - Stop keeps values; restart at pattern one
// - Fourteen sixteen-bit balance values
module tcb_ctrl
    import tcb_pkg::*;
#(
    parameter int TICK_CYC = `TCB_TICK_CYC,
    parameter int BLANK_CYC = `TCB_BLANK_CYC,
    parameter int NCELL = `TCB_NCELL
) (
    input wire logic clk,
    input wire logic rstn,
    input tcb_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    input tcb_cmd_t cmd,
    input wire logic wdt_expire,
    output logic scan_start,
    input wire logic scan_done,
    input wire logic scan_fault,
    input tcb_volt_t cell_volt,
    input wire logic cscan_req,
    output logic cscan_go,
    input wire logic cscan_done,
    output logic [NCELL-1:0] cb_out,
    output logic sleep_req,
    output logic reg_off,
    output logic end_flag,
    output logic wdt_flag
);
    localparam int BW = $clog2(BLANK_CYC + 1);

    // Programmed on-time in seconds
    function automatic logic [11:0] on_secs(input logic [6:0] code);
        on_secs = 12'(code) * 12'(`TCB_STEP_S);
    endfunction

    // Wait code to seconds, zero for code zero
    function automatic logic [6:0] wait_secs(input logic [2:0] code);
        wait_secs = (code == 3'h0) ? 7'h00 : (7'h01 << (code - 3'h1));
    endfunction

    // Address falls in a fourteen-word window
    function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
        in_win = (a >= base) && (a < base + 8'(NCELL));
    endfunction

    // Charge left after a scan, never below zero
    function automatic logic [15:0] sat_sub(input logic [15:0] v, input logic [15:0] d);
        sat_sub = (v > d) ? v - d : 16'h0000;
    endfunction

    // Configuration and control state
    logic [1:0] mode;
    logic [2:0] wait_time_field;
    logic scan_blanking_bit;
    logic ibal;
    logic balance_enable_bit;
    logic [6:0] on_time_field;
    logic [7:0] wdog;
    logic [NCELL-1:0] pat [NCELL]; // Cell patterns, index 0 is pattern one
    logic [15:0] bval [NCELL]; // Charge left per cell
    tcb_state_t st, next_st;
    logic [3:0] pidx; // Active pattern index
    logic [11:0] on_left; // Seconds of on-time left
    logic [6:0] wait_left; // Seconds of wait left
    logic sleep_arm; // Sleep pending on balance end
    tcb_blank_t bl_st;
    logic bl_dark; // Outputs held off for a scan
    logic [BW-1:0] bl_cnt;
    logic tick;
    logic [15:0] next_bval [NCELL];
    logic all_zero;

    // One-second time base
    tcb_tick #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    // Register and command decode
    wire wr_setup = reg_req.wr && (reg_req.addr == `TCB_SETUP_ADDR);
    wire wr_time = reg_req.wr && (reg_req.addr == `TCB_TIME_ADDR);
    wire wr_stat = reg_req.wr && (reg_req.addr == `TCB_STAT_ADDR);
    wire wr_val = reg_req.wr && in_win(reg_req.addr, `TCB_VAL_ADDR);
    wire wr_pat = reg_req.wr && in_win(reg_req.addr, `TCB_PAT_ADDR);
    wire [3:0] val_i = 4'(reg_req.addr - `TCB_VAL_ADDR);
    wire [3:0] pat_i = 4'(reg_req.addr - `TCB_PAT_ADDR);
    wire w_ben = reg_req.wdata[`TCB_BEN_BIT];
    wire c_en = cmd.valid && (cmd.code == `TCB_CMD_ENABLE);
    wire c_inh = cmd.valid && (cmd.code == `TCB_CMD_INHIBIT);
    wire c_slp = cmd.valid && (cmd.code == `TCB_CMD_SLEEP);
    wire c_wake = cmd.valid && (cmd.code == `TCB_CMD_WAKE);

    // Mode taken with the write that sets enable
    wire [1:0] mode_eff = wr_setup ? reg_req.wdata[`TCB_MODE_LSB +: 2] : mode;
    wire start_req = c_en || (wr_setup && w_ben && !balance_enable_bit);
    wire stop_req = c_inh || (wr_setup && !w_ben && balance_enable_bit);
    wire busy = (st != ST_IDLE);
    wire wdt_hit = wdt_expire && busy;
    wire is_auto = (mode == `TCB_MD_AUTO);

    // Timer expiry; timed code zero never expires
    wire on_exp = (st == ST_ON) && (mode != `TCB_MD_MANUAL)
        && ((on_left == 12'h000 && is_auto) || (tick && on_left == 12'h001));
    wire scan_ok = (st == ST_SCAN) && scan_done && !scan_fault;
    wire fhalt = (st == ST_SCAN) && scan_done && scan_fault;
    wire tend = on_exp && !is_auto && !stop_req && !wdt_hit;
    wire aend = scan_ok && all_zero && !stop_req && !wdt_hit;
    wire fin = tend || aend || fhalt;
    wire enter_on = (next_st == ST_ON) && ((st != ST_ON) || start_req);

    // Next pattern, wrapping at a zero pattern or the last one
    wire [3:0] pidx_inc = pidx + 4'h1;
    wire wrap = (pidx == 4'(NCELL - 1)) || (pat[pidx_inc] == '0);
    wire [3:0] pidx_nxt = wrap ? 4'h0 : pidx_inc;

    // In auto mode, cells whose charge is used up drop out of the pattern
    logic [NCELL-1:0] zmask;
    always_comb begin
        for (int i = 0; i < NCELL; i++) begin
            zmask[i] = (bval[i] == 16'h0000);
        end
    end
    wire [NCELL-1:0] act = is_auto ? (pat[pidx] & ~zmask) : pat[0];
    wire [NCELL-1:0] next_cb = (st == ST_ON && !bl_dark) ? act : '0;

    // Charge accounting for the cells just balanced
    always_comb begin
        all_zero = 1'b1;
        for (int i = 0; i < NCELL; i++) begin
            next_bval[i] = act[i] ? sat_sub(bval[i], cell_volt[i]) : bval[i];
            all_zero = all_zero && (next_bval[i] == 16'h0000);
        end
    end

    // Sequencer next state
    always_comb begin
        next_st = st;
        case (st)
            ST_IDLE: next_st = ST_IDLE;
            ST_ON: begin
                if (on_exp) begin
                    next_st = is_auto ? ST_SCAN : ST_IDLE;
                end
            end
            ST_SCAN: begin
                if (scan_done) begin
                    next_st = (scan_fault || all_zero) ? ST_IDLE : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_left == 7'h00) begin
                    next_st = ST_ON;
                end
            end
            default: next_st = ST_IDLE;
        endcase
        if (start_req) begin
            next_st = (mode_eff != `TCB_MD_OFF) ? ST_ON : ST_IDLE;
        end
        if (stop_req || wdt_hit) begin
            next_st = ST_IDLE;
        end
    end

    // Sequencer state and timers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= ST_IDLE;
            on_left <= 12'h000;
            wait_left <= 7'h00;
            pidx <= 4'h0;
        end else begin
            st <= next_st;
            // Fresh full on-time on every entry
            if (enter_on) begin
                on_left <= on_secs(on_time_field);
            end else if (st == ST_ON && tick && on_left != 12'h000) begin
                on_left <= on_left - 12'h001;
            end
            if (next_st == ST_WAIT && st != ST_WAIT) begin
                wait_left <= wait_secs(wait_time_field);
            end else if (tick && wait_left != 7'h00) begin
                wait_left <= wait_left - 7'h01;
            end
            // Restart always begins from pattern one
            if (start_req) begin
                pidx <= 4'h0;
            end else if (st == ST_WAIT && next_st == ST_ON) begin
                pidx <= pidx_nxt;
            end
        end
    end

    // Configuration writes and enable bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= `TCB_MD_OFF;
            wait_time_field <= 3'h0;
            scan_blanking_bit <= 1'b0;
            ibal <= 1'b0;
            balance_enable_bit <= 1'b0;
            on_time_field <= 7'h00;
            wdog <= `TCB_WDOG_RST;
        end else begin
            if (wr_setup) begin
                mode <= reg_req.wdata[`TCB_MODE_LSB +: 2];
                wait_time_field <= reg_req.wdata[`TCB_BWT_LSB +: 3];
                scan_blanking_bit <= reg_req.wdata[`TCB_SCAN_BLANKING_BIT_BIT];
                ibal <= reg_req.wdata[`TCB_IBAL_BIT];
            end
            if (wr_time) begin
                on_time_field <= reg_req.wdata[`TCB_BTM_LSB +: 7];
                wdog <= reg_req.wdata[`TCB_WDOG_LSB +: 8];
            end
            if (fin) begin
                balance_enable_bit <= 1'b0;
            end
            if (start_req) begin
                balance_enable_bit <= 1'b1;
            end
            if (stop_req || wdt_hit) begin
                balance_enable_bit <= 1'b0;
            end
        end
    end

    // Pattern and balance value storage; stop leaves values alone
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NCELL; i++) begin
                pat[i] <= '0;
                bval[i] <= 16'h0000;
            end
        end else begin
            if (scan_ok) begin
                for (int i = 0; i < NCELL; i++) begin
                    bval[i] <= next_bval[i];
                end
            end
            // A host write lands after the scan update
            if (wr_val) begin
                bval[val_i] <= reg_req.wdata;
            end
            if (wr_pat) begin
                pat[pat_i] <= reg_req.wdata[NCELL-1:0];
            end
        end
    end

    // Flags and sleep; hardware set wins over a clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            end_flag <= 1'b0;
            wdt_flag <= 1'b0;
            sleep_arm <= 1'b0;
            sleep_req <= 1'b0;
        end else begin
            if ((wr_setup && !reg_req.wdata[`TCB_EOB_BIT])
                || (wr_stat && reg_req.wdata[`TCB_ST_END_BIT])) begin
                end_flag <= 1'b0;
            end
            if (tend || aend) begin
                end_flag <= 1'b1;
            end
            if (wr_stat && reg_req.wdata[`TCB_ST_WDT_BIT]) begin
                wdt_flag <= 1'b0;
            end
            if (wdt_hit) begin
                wdt_flag <= 1'b1;
            end
            // Sleep while running only arms; balancing goes on
            if (next_st == ST_IDLE) begin
                sleep_arm <= 1'b0;
            end else if (c_slp && busy) begin
                sleep_arm <= 1'b1;
            end
            if (c_wake) begin
                sleep_req <= 1'b0;
            end
            if ((c_slp && !busy) || (sleep_arm && fin) || wdt_hit) begin
                sleep_req <= 1'b1;
            end
        end
    end

    // Regulators drop in armed auto waits only
    assign reg_off = sleep_arm && (st == ST_WAIT);

    // Continuous-scan blanking: dark, lead time, scan, restore
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bl_st <= BL_IDLE;
            bl_dark <= 1'b0;
            bl_cnt <= '0;
            cscan_go <= 1'b0;
        end else begin
            cscan_go <= 1'b0;
            case (bl_st)
                BL_IDLE: begin
                    if (cscan_req && scan_blanking_bit && busy) begin
                        bl_st <= BL_LEAD;
                        bl_dark <= 1'b1;
                        bl_cnt <= BW'(BLANK_CYC);
                    end else if (cscan_req) begin
                        bl_st <= BL_SCAN;
                        cscan_go <= 1'b1;
                    end
                end
                BL_LEAD: begin
                    if (bl_cnt == '0) begin
                        bl_st <= BL_SCAN;
                        cscan_go <= 1'b1;
                    end else begin
                        bl_cnt <= bl_cnt - BW'(1);
                    end
                end
                BL_SCAN: begin
                    if (cscan_done) begin
                        bl_st <= BL_IDLE;
                        bl_dark <= 1'b0;
                    end
                end
                default: bl_st <= BL_IDLE;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    wire [15:0] rd_setup = {7'h00, ibal, end_flag, scan_blanking_bit, balance_enable_bit, wait_time_field, mode};
    wire [15:0] rd_time = {1'b0, on_time_field, wdog};
    wire [15:0] rd_stat = {8'h00, pidx, busy, 1'b0, wdt_flag, end_flag};
    wire [15:0] rd_mux =
        (reg_req.addr == `TCB_SETUP_ADDR) ? rd_setup :
        (reg_req.addr == `TCB_TIME_ADDR) ? rd_time :
        (reg_req.addr == `TCB_STAT_ADDR) ? rd_stat :
        in_win(reg_req.addr, `TCB_VAL_ADDR) ? bval[val_i] :
        in_win(reg_req.addr, `TCB_PAT_ADDR) ? 16'(pat[pat_i]) : 16'h0000;

    // Registered outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
            cb_out <= '0;
            scan_start <= 1'b0;
        end else begin
            if (reg_req.rd) begin
                reg_rdata <= rd_mux;
            end
            cb_out <= next_cb;
            scan_start <= (next_st == ST_SCAN) && (st != ST_SCAN);
        end
    end

    default clocking cb_clk @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_blank_start;
        bl_st == BL_IDLE && cscan_req && scan_blanking_bit && busy;
    endsequence
    sequence s_auto_cycle_end;
        st == ST_WAIT ##1 st == ST_ON;
    endsequence

    stop_clears_a: assert property (stop_req && !start_req |=> st == ST_IDLE && !balance_enable_bit ##1 cb_out == '0)
        else $error("stop did not halt balancing");
    start_full_a: assert property ((st != ST_ON ##1 st == ST_ON && !is_auto) |-> on_left == on_secs(on_time_field))
        else $error("on-time not reloaded in full");
    timed_end_a: assert property (tend |=> end_flag && !balance_enable_bit && st == ST_IDLE)
        else $error("timed end missed flag or enable");
    wdt_sleep_a: assert property (wdt_hit |=> st == ST_IDLE && sleep_req && wdt_flag ##1 cb_out == '0)
        else $error("watchdog did not stop and sleep");
    blank_lead_a: assert property (s_blank_start |-> ##2 (cb_out == '0 && !cscan_go)[*8])
        else $error("outputs not dark ahead of scan");
    sleep_keeps_a: assert property (c_slp && st == ST_ON && !on_exp && !stop_req && !wdt_hit && !start_req
        |=> st == ST_ON && sleep_arm && !sleep_req)
        else $error("sleep stopped a running balance");
    auto_done_a: assert property (aend && sleep_arm |=> sleep_req && end_flag && !balance_enable_bit)
        else $error("auto completion not handled");
    fault_halt_a: assert property (fhalt && !start_req |=> st == ST_IDLE && !balance_enable_bit ##1 cb_out == '0)
        else $error("fault did not halt auto balance");
    wrap_seq_a: assert property (s_auto_cycle_end |-> pidx == 4'h0 || pat[pidx] != '0)
        else $error("pattern sequence did not wrap");
    scan_sub_a: assert property (scan_ok && act[0] && !wr_val |=> bval[0] == sat_sub($past(bval[0]), $past(cell_volt[0])))
        else $error("balance value not reduced");
endmodule

/* File: core/tcb_cfg.svh */
`ifndef TCB_CFG_SVH
`define TCB_CFG_SVH
// Clock and time base
`define TCB_CLK_HZ 25000000
`define TCB_TICK_S 1
`define TCB_TICK_CYC (`TCB_CLK_HZ * `TCB_TICK_S)
`define TCB_BLANK_MS 10
`define TCB_BLANK_CYC (`TCB_CLK_HZ / 1000 * `TCB_BLANK_MS)
`define TCB_STEP_S 20
`define TCB_NCELL 14
// Register page+address map
`define TCB_SETUP_ADDR 8'h90
`define TCB_TIME_ADDR 8'h91
`define TCB_STAT_ADDR 8'h92
`define TCB_VAL_ADDR 8'hA0
`define TCB_PAT_ADDR 8'hB0
// Setup register fields
`define TCB_MODE_LSB 0
`define TCB_BWT_LSB 2
`define TCB_BEN_BIT 5
`define TCB_SCAN_BLANKING_BIT_BIT 6
`define TCB_EOB_BIT 7
`define TCB_IBAL_BIT 8
// Time register fields
`define TCB_WDOG_LSB 0
`define TCB_BTM_LSB 8
`define TCB_WDOG_RST 8'h3F
// Status register fields
`define TCB_ST_END_BIT 0
`define TCB_ST_WDT_BIT 1
// Mode encodings
`define TCB_MD_OFF 2'h0
`define TCB_MD_MANUAL 2'h1
`define TCB_MD_TIMED 2'h2
`define TCB_MD_AUTO 2'h3
// Command page+address bytes
`define TCB_CMD_ENABLE 8'hCA
`define TCB_CMD_INHIBIT 8'hC9
`define TCB_CMD_SLEEP 8'hC4
`define TCB_CMD_WAKE 8'hC6
`endif

/* File: core/tcb_pkg.sv */
`include "tcb_cfg.svh"
package tcb_pkg;
    // Balance sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_SCAN, ST_WAIT} tcb_state_t;
    // Continuous-scan blanking states
    typedef enum logic [1:0] {BL_IDLE, BL_LEAD, BL_SCAN} tcb_blank_t;
    // Register access from the command link
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } tcb_reg_req_t;
    // Zero-length command from the link
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } tcb_cmd_t;
    // Cell voltages from an auto-balance scan
    typedef logic [`TCB_NCELL-1:0][15:0] tcb_volt_t;
endpackage

/* File: core/tcb_tick.sv */
`timescale 1ns/1ns
`include "tcb_cfg.svh"
// One-second enable from the free-running oscillator clock
module tcb_tick #(
    parameter int TICK_CYC = `TCB_TICK_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    output logic tick
);
    localparam int CW = $clog2(TICK_CYC);
    logic [CW-1:0] cnt; // Cycles into current second
    wire wrap = (cnt == CW'(TICK_CYC - 1));

    // Never gated, so sleep-time balancing keeps its pace
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= wrap ? '0 : cnt + CW'(1);
            tick <= wrap;
        end
    end
endmodule

/* File: tb/tcb_scan_model.sv */
`timescale 1ns/1ns
`include "tcb_cfg.svh"
// Scan engine stand-in: answers each auto scan after a fixed delay
module tcb_scan_model
    import tcb_pkg::*;
#(
    parameter int DLY = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic fault,
    input wire logic scan_start,
    output logic scan_done,
    output logic scan_fault,
    output tcb_volt_t cell_volt
);
    logic [3:0] cnt; // Cycles left until the answer
    // One answer per request, nothing unasked
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            scan_done <= 1'b0;
        end else begin
            scan_done <= (cnt == 4'h1);
            if (scan_start) begin
                cnt <= DLY[3:0];
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
    // Fault only when the bench asks; volts are junk off the answer cycle
    assign scan_fault = scan_done & fault;
    assign cell_volt = scan_done ? {`TCB_NCELL{16'h0001}} : {`TCB_NCELL{16'hFFFE}};
endmodule

/* File: tb/timed_auto_cell_balance_ctrl_test.sv */
`timescale 1ns/1ns
`include "tcb_cfg.svh"
module timed_auto_cell_balance_ctrl_test
    import tcb_pkg::*;
;
    localparam int BLK = 12; // Shortened blanking lead
    logic clk = 1'b0;
    logic rstn = 1'b0;
    tcb_reg_req_t reg_req = '0;
    tcb_cmd_t cmd = '0;
    logic wdt_expire = 1'b0;
    logic cscan_req = 1'b0;
    logic cscan_done = 1'b0;
    logic fault = 1'b0; // Asks the scan model for a fault
    logic [15:0] reg_rdata;
    logic scan_start, scan_done, scan_fault, cscan_go;
    tcb_volt_t cell_volt;
    logic [13:0] cb_out;
    logic sleep_req, reg_off, end_flag, wdt_flag;
    logic [15:0] rv; // Last read word
    int n; // Cycles counted by the last wait
    int fail_count = 0;
    int samples_checked = 0;

    tcb_ctrl #(.TICK_CYC(50), .BLANK_CYC(BLK)) u_tcb_ctrl (
        .clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .cmd(cmd), .wdt_expire(wdt_expire), .scan_start(scan_start),
        .scan_done(scan_done), .scan_fault(scan_fault), .cell_volt(cell_volt),
        .cscan_req(cscan_req), .cscan_go(cscan_go), .cscan_done(cscan_done),
        .cb_out(cb_out), .sleep_req(sleep_req), .reg_off(reg_off),
        .end_flag(end_flag), .wdt_flag(wdt_flag));
    tcb_scan_model u_tcb_scan_model (
        .clk(clk), .rstn(rstn), .fault(fault), .scan_start(scan_start),
        .scan_done(scan_done), .scan_fault(scan_fault), .cell_volt(cell_volt));

    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    // Settle past the edge before looking
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        reg_req <= '0;
    endtask
    // Data read one edge late, safe since it holds until the next read
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        reg_req <= '0;
        step(1);
        rv = reg_rdata;
    endtask
    task automatic send(input logic [7:0] c);
        @(posedge clk);
        cmd <= '{1'b1, c};
        @(posedge clk);
        cmd <= '0;
        step(2);
    endtask
    // Bounded wait for an output pattern
    task automatic wait_cb(input logic [13:0] v);
        n = 0;
        while (cb_out !== v) begin
            step(1);
            n++;
            if (n > 3000) begin
                fail_count++;
                $display("MISMATCH cb_out wait expected %h seen %h", v, cb_out);
                print_verdict();
            end
        end
    endtask
    // Scan request, then cycles from the taking edge until the go pulse
    task automatic scan_ask();
        @(posedge clk);
        cscan_req <= 1'b1;
        @(posedge clk);
        cscan_req <= 1'b0;
        n = 0;
        #1;
        while (cscan_go !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        if (n >= 40) begin
            chk("cscan_go wait", 16'(cscan_go), 16'h0001);
            print_verdict();
        end
    endtask
    // One-cycle end-of-scan pulse, so blanking returns to idle
    task automatic scan_end();
        @(posedge clk);
        cscan_done <= 1'b1;
        @(posedge clk);
        cscan_done <= 1'b0;
    endtask
    task automatic t_regs();
        rd(8'h90);
        chk("setup reset", rv, 16'h0000);
        rd(8'h91);
        chk("time reset", rv, 16'h003F);
        rd(8'h55);
        chk("unmapped read", rv, 16'h0000);
        wr(8'hB0, 16'h0082);
        rd(8'hB0);
        chk("pattern one", rv, 16'h0082);
        $display("test regs done");
    endtask
    task automatic t_timed();
        wr(8'h91, 16'h013F);
        wr(8'h90, 16'h0002);
        send(`TCB_CMD_ENABLE);
        chk("timed on", 16'(cb_out), 16'h0082);
        step(600);
        send(`TCB_CMD_INHIBIT);
        chk("stopped", 16'(cb_out), 16'h0000);
        send(`TCB_CMD_ENABLE);
        wait_cb(14'h0000);
        chk("full on time", 16'(n >= 930 && n <= 1010), 16'h0001);
        step(2);
        chk("end flag", 16'(end_flag), 16'h0001);
        rd(8'h90);
        chk("eob set ben clear", rv & 16'h00A0, 16'h0080);
        wr(8'h92, 16'h0003);
        step(2);
        chk("end flag clear", 16'(end_flag), 16'h0000);
        $display("test timed done");
    endtask
    task automatic t_sleep();
        send(`TCB_CMD_ENABLE);
        send(`TCB_CMD_SLEEP);
        chk("no early sleep", 16'(sleep_req), 16'h0000);
        chk("balance in sleep", 16'(cb_out), 16'h0082);
        wait_cb(14'h0000);
        step(2);
        chk("sleep at end", 16'(sleep_req), 16'h0001);
        send(`TCB_CMD_WAKE);
        chk("woken", 16'(sleep_req), 16'h0000);
        wr(8'h92, 16'h0003);
        $display("test sleep done");
    endtask
    task automatic t_wdog();
        send(`TCB_CMD_ENABLE);
        send(`TCB_CMD_SLEEP);
        @(posedge clk);
        wdt_expire <= 1'b1;
        @(posedge clk);
        wdt_expire <= 1'b0;
        step(2);
        chk("watchdog stop", 16'(cb_out), 16'h0000);
        chk("watchdog sleep", 16'(sleep_req), 16'h0001);
        chk("watchdog flag", 16'(wdt_flag), 16'h0001);
        send(`TCB_CMD_WAKE);
        wr(8'h92, 16'h0003);
        $display("test watchdog done");
    endtask
    task automatic t_ben_low();
        send(`TCB_CMD_ENABLE);
        wr(8'h90, 16'h0002);
        step(2);
        chk("enable low stop", 16'(cb_out), 16'h0000);
        $display("test enable low done");
    endtask
    task automatic t_blank();
        wr(8'h90, 16'h0062);
        step(2);
        scan_ask();
        chk("blank lead", 16'(n), 16'(BLK + 1));
        chk("dark in scan", 16'(cb_out), 16'h0000);
        scan_end();
        wait_cb(14'h0082);
        chk("restored", 16'(n <= 4), 16'h0001);
        wr(8'h90, 16'h0022);
        step(2);
        scan_ask();
        chk("no blank go", 16'(n), 16'h0000);
        chk("stays on", 16'(cb_out), 16'h0082);
        scan_end();
        send(`TCB_CMD_INHIBIT);
        $display("test blanking done");
    endtask
    task automatic t_auto();
        wr(8'hA0, 16'h0001);
        wr(8'hA1, 16'h0002);
        wr(8'hA2, 16'h0001);
        wr(8'hB0, 16'h0003);
        wr(8'hB1, 16'h0004);
        wr(8'hB2, 16'h0000); // Empty third pattern forces the wrap
        wr(8'h91, 16'h013F);
        wr(8'h90, 16'h0067);
        wait_cb(14'h0003);
        send(`TCB_CMD_SLEEP);
        chk("regs on in run", 16'(reg_off), 16'h0000);
        scan_ask();
        chk("auto blank lead", 16'(n), 16'(BLK + 1));
        scan_end();
        wait_cb(14'h0003);
        wait_cb(14'h0000);
        // Scan answer lands four edges on; the one-second wait follows
        step(6);
        chk("regs off in wait", 16'(reg_off), 16'h0001);
        wait_cb(14'h0004);
        chk("wait gap", 16'(n <= 70), 16'h0001);
        wait_cb(14'h0000);
        wait_cb(14'h0002);
        wait_cb(14'h0000);
        step(20);
        chk("auto end", 16'(end_flag), 16'h0001);
        chk("sleep at auto end", 16'(sleep_req), 16'h0001);
        send(`TCB_CMD_WAKE);
        rd(8'hA1);
        chk("value drained", rv, 16'h0000);
        rd(8'h90);
        chk("auto ben clear", rv & 16'h0020, 16'h0000);
        wr(8'h92, 16'h0003);
        $display("test auto done");
    endtask
    task automatic t_fault();
        wr(8'hA0, 16'h0005);
        wr(8'h90, 16'h0027);
        // Cell two was drained by the auto test, so only cell one runs
        wait_cb(14'h0001);
        @(posedge clk);
        fault <= 1'b1;
        wait_cb(14'h0000);
        step(100);
        chk("fault halt", 16'(cb_out), 16'h0000);
        rd(8'h92);
        chk("not busy", rv & 16'h0008, 16'h0000);
        @(posedge clk);
        fault <= 1'b0;
        $display("test fault done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        step(1);
        t_regs();
        t_timed();
        t_sleep();
        t_wdog();
        t_ben_low();
        t_blank();
        t_auto();
        t_fault();
        print_verdict();
    end
endmodule
